/* File: verilog/nmi_enable_defines.svh */
`ifndef NMI_ENABLE_DEFINES_SVH
`define NMI_ENABLE_DEFINES_SVH

// =====================================================================
// register offsets (byte addresses)
`define DIRECT_OFFSET      12'h320
`define SET_OFFSET         12'h324
`define STATUS_OFFSET      12'h340
`define MASK_OFFSET        12'h344

// =====================================================================
// field positions
`define WATCH0_WRITE_BIT   0
`define WATCH0_READ_BIT    1
`define WATCH1_WRITE_BIT   2
`define WATCH1_READ_BIT    3
`define WATCH2_WRITE_BIT   4
`define WATCH2_READ_BIT    5
`define WATCH3_WRITE_BIT   6
`define WATCH3_READ_BIT    7
`define PERIPH0_WRITE_BIT  8
`define PERIPH0_READ_BIT   9
`define PERIPH1_WRITE_BIT  10
`define PERIPH1_READ_BIT   11
`define EVENT_COUNT        12

// =====================================================================
// reset values
`define ENABLE_RESET       12'h000
`define STATUS_RESET       12'h000
`define MASK_RESET         12'h000

// =====================================================================
// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: verilog/nmi_enable_pkg.sv */
package nmi_enable_pkg;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_BUSY = 2'b01
    } read_state_t;
    typedef logic [11:0] event_vec_t;
endpackage

/* File: verilog/event_flag.sv */
`timescale 1ns/1ps
`include "nmi_enable_defines.svh"

// one sticky bit; a set in the same cycle as a clear wins
module event_flag (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // control
    input  wire logic setIn,
    input  wire logic clearIn,
    // state
    output logic      flag
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clearIn) begin
            flag_d = 1'b0;
        end
        if (setIn) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else if (clkEn) begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

/* File: verilog/watch_event_nmi_enable.sv */
`timescale 1ns/1ps
`include "nmi_enable_defines.svh"

// Overview of operation
// - A one written to a bit of the set register turns on the NMI for that event.
// - Reading the set register returns each event's current NMI enable state.
// - The direct register holds a read-write enable bit for peripheral region 1 read access.
// - The set register has separate read and write bits per region, each setting only itself.
// - A one on the region 2 write bit enables only that event's NMI.
module watch_event_nmi_enable #(
    parameter int EVENTS = `EVENT_COUNT
) (
    // clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    // axi4-lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // watch events, one-cycle pulses from same-clock logic
    input  wire logic [EVENTS-1:0] watchEvent,
    // outputs
    output logic                   nmiOut,
    output logic                   irqOut
);
    // =================================================================
    // write channel
    logic              awHeld_q, awHeld_d;
    logic              wHeld_q, wHeld_d;
    logic [11:0]       awAddr_q, awAddr_d;
    logic [31:0]       wData_q, wData_d;
    logic [3:0]        wStrb_q, wStrb_d;
    logic              bValid_q, bValid_d;
    logic [1:0]        bResp_q, bResp_d;
    logic [EVENTS-1:0] enable_q, enable_d;
    logic [EVENTS-1:0] mask_q, mask_d;
    logic [EVENTS-1:0] statusClr;
    logic [EVENTS-1:0] status;
    logic              doWrite;
    logic [31:0]       wMasked;

    // frozen: refuse new work, else a taken request would be lost
    assign s_axi_awready = !awHeld_q && !bValid_q && clkEn;
    assign s_axi_wready  = !wHeld_q && !bValid_q && clkEn;
    assign doWrite       = awHeld_q && wHeld_q && !bValid_q;

    always_comb begin
        awHeld_d  = awHeld_q;
        wHeld_d   = wHeld_q;
        awAddr_d  = awAddr_q;
        wData_d   = wData_q;
        wStrb_d   = wStrb_q;
        bValid_d  = bValid_q;
        bResp_d   = bResp_q;
        enable_d  = enable_q;
        mask_d    = mask_q;
        statusClr = '0;
        wMasked   = '0;
        for (int i = 0; i < 4; i++) begin
            wMasked[i*8 +: 8] = wStrb_q[i] ? wData_q[i*8 +: 8] : 8'h00;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bValid_d = 1'b1;
            bResp_d  = `RESP_OKAY;
            unique case (awAddr_q)
                `DIRECT_OFFSET: begin
                    // byte lanes honoured per bit
                    for (int i = 0; i < EVENTS; i++) begin
                        if (wStrb_q[i/8]) begin
                            enable_d[i] = wData_q[i];
                        end
                    end
                end
                `SET_OFFSET: begin
                    // ones set, zeros leave alone
                    enable_d = enable_q | wMasked[EVENTS-1:0];
                end
                `STATUS_OFFSET: statusClr = wMasked[EVENTS-1:0];
                `MASK_OFFSET: mask_d = wMasked[EVENTS-1:0];
                default: bResp_d = `RESP_SLVERR;
            endcase
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q  <= 32'h00000000;
            wStrb_q  <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q  <= `RESP_OKAY;
            enable_q <= `ENABLE_RESET;
            mask_q   <= `MASK_RESET;
        end else if (clkEn) begin
            awHeld_q <= awHeld_d;
            wHeld_q  <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q  <= wData_d;
            wStrb_q  <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q  <= bResp_d;
            enable_q <= enable_d;
            mask_q   <= mask_d;
        end
    end

    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp  = bResp_q;

    // =================================================================
    // sticky event status, set beats clear
    for (genvar g = 0; g < EVENTS; g++) begin : gFlag
        event_flag uFlag (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .clkEn   (clkEn),
            .setIn   (watchEvent[g]),
            .clearIn (statusClr[g]),
            .flag    (status[g])
        );
    end

    // =================================================================
    // outputs
    logic nmi_q, nmi_d;
    logic irq_q, irq_d;

    always_comb begin
        nmi_d = |(status & enable_q);
        irq_d = |(status & mask_q);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nmi_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clkEn) begin
            nmi_q <= nmi_d;
            irq_q <= irq_d;
        end
    end

    assign nmiOut = nmi_q;
    assign irqOut = irq_q;

    // =================================================================
    // read channel
    nmi_enable_pkg::read_state_t rdState_q, rdState_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0]  rResp_q, rResp_d;

    // limitation: bready/rready must stay low while clkEn is low
    assign s_axi_arready = (rdState_q == nmi_enable_pkg::RD_IDLE) && clkEn;

    always_comb begin
        rdState_d = rdState_q;
        rData_d   = rData_q;
        rResp_d   = rResp_q;
        unique case (rdState_q)
            nmi_enable_pkg::RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rdState_d = nmi_enable_pkg::RD_BUSY;
                    rData_d   = 32'h00000000;
                    rResp_d   = `RESP_OKAY;
                    unique case (s_axi_araddr)
                        `DIRECT_OFFSET: rData_d[EVENTS-1:0] = enable_q;
                        `SET_OFFSET:    rData_d[EVENTS-1:0] = enable_q;
                        `STATUS_OFFSET: rData_d[EVENTS-1:0] = status;
                        `MASK_OFFSET:   rData_d[EVENTS-1:0] = mask_q;
                        default:        rResp_d = `RESP_SLVERR;
                    endcase
                end
            end
            nmi_enable_pkg::RD_BUSY: begin
                if (s_axi_rready) begin
                    rdState_d = nmi_enable_pkg::RD_IDLE;
                end
            end
            default: rdState_d = nmi_enable_pkg::RD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdState_q <= nmi_enable_pkg::RD_IDLE;
            rData_q   <= 32'h00000000;
            rResp_q   <= `RESP_OKAY;
        end else if (clkEn) begin
            rdState_q <= rdState_d;
            rData_q   <= rData_d;
            rResp_q   <= rResp_d;
        end
    end

    assign s_axi_rvalid = (rdState_q == nmi_enable_pkg::RD_BUSY);
    assign s_axi_rdata  = rData_q;
    assign s_axi_rresp  = rResp_q;

    // =================================================================
    // checks
    set_bit_on_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite && awAddr_q == `SET_OFFSET && wStrb_q[0] && wData_q[0])
        |=> enable_q[0]) else $error("set write did not enable bit 0");
    read_shows_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && s_axi_arvalid && s_axi_arready && s_axi_araddr == `SET_OFFSET)
        |=> s_axi_rdata[EVENTS-1:0] == $past(enable_q))
        else $error("set read does not show enables");
    direct_write_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite && awAddr_q == `DIRECT_OFFSET && wStrb_q[1])
        |=> enable_q[`PERIPH1_READ_BIT] == $past(wData_q[`PERIPH1_READ_BIT]))
        else $error("direct write lost peripheral region 1 read bit");
    bit_isolate_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite && awAddr_q == `SET_OFFSET
         && wMasked[11:0] == 12'h008)
        |=> enable_q == ($past(enable_q) | 12'h008))
        else $error("region 1 read bit touched other enables");
    region2_write_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite && awAddr_q == `SET_OFFSET
         && wMasked[11:0] == 12'h010)
        |=> enable_q == ($past(enable_q) | 12'h010))
        else $error("region 2 write bit touched other enables");
    zero_keeps_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite && awAddr_q == `SET_OFFSET)
        |=> (enable_q & $past(enable_q)) == $past(enable_q))
        else $error("set write cleared an enable");
    nmi_follows_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && |(status & enable_q)) |=> nmiOut)
        else $error("nmi missing for enabled event");
    resp_after_a : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clkEn && doWrite) |=> s_axi_bvalid)
        else $error("write response missing");
endmodule

/* File: bench/watch_event_nmi_enable_test.sv */
`timescale 1ns/1ps
`include "nmi_enable_defines.svh"

module watch_event_nmi_enable_test;
    // ================================================================
    // clock, reset and design ports
    logic                     ref_clk       = 1'b0;
    logic                     sys_rst       = 1'b1;
    logic                     clkEn         = 1'b1;
    logic [11:0]              s_axi_awaddr  = 12'h000;
    logic                     s_axi_awvalid = 1'b0;
    logic                     s_axi_awready;
    logic [31:0]              s_axi_wdata   = 32'h0000_0000;
    logic [3:0]               s_axi_wstrb   = 4'hF;
    logic                     s_axi_wvalid  = 1'b0;
    logic                     s_axi_wready;
    logic [1:0]               s_axi_bresp;
    logic                     s_axi_bvalid;
    logic                     s_axi_bready  = 1'b0;
    logic [11:0]              s_axi_araddr  = 12'h000;
    logic                     s_axi_arvalid = 1'b0;
    logic                     s_axi_arready;
    logic [31:0]              s_axi_rdata;
    logic [1:0]               s_axi_rresp;
    logic                     s_axi_rvalid;
    logic                     s_axi_rready  = 1'b0;
    logic [`EVENT_COUNT-1:0]  watchEvent    = '0;
    logic                     nmiOut;
    logic                     irqOut;
    logic                     nmiSeen;
    logic                     irqSeen;
    int                       nFail         = 0;
    int                       testsRun      = 0;

    always #2 ref_clk = ~ref_clk;

    watch_event_nmi_enable DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchEvent(watchEvent),
        .nmiOut(nmiOut), .irqOut(irqOut)
    );

    // ================================================================
    // reporting
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ================================================================
    // bus master; handshakes sampled at the falling edge, where the
    // values equal those seen by the next rising edge without a race
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awHit, wHit, bHit;
        int   n;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        bHit = 1'b0;
        n = 0;
        while (!bHit && n < 50) begin
            @(negedge ref_clk);
            awHit = s_axi_awvalid && s_axi_awready;
            wHit  = s_axi_wvalid && s_axi_wready;
            bHit  = s_axi_bvalid && s_axi_bready;
            if (bHit) check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge ref_clk);
            if (awHit) s_axi_awvalid <= 1'b0;
            if (wHit) s_axi_wvalid <= 1'b0;
            if (bHit) s_axi_bready <= 1'b0;
            n++;
        end
        if (!bHit) check("write answer", 32'h0, 32'h1);
    endtask

    task automatic reg_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
                            input string what);
        logic arHit, rHit;
        int   n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        rHit = 1'b0;
        n = 0;
        while (!rHit && n < 50) begin
            @(negedge ref_clk);
            arHit = s_axi_arvalid && s_axi_arready;
            rHit  = s_axi_rvalid && s_axi_rready;
            if (rHit) check(what, s_axi_rdata, ed);
            if (rHit) check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge ref_clk);
            if (arHit) s_axi_arvalid <= 1'b0;
            if (rHit) s_axi_rready <= 1'b0;
            n++;
        end
        if (!rHit) check("read answer", 32'h0, 32'h1);
    endtask

    // outputs lag two edges behind their cause
    task automatic sample_outs();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        nmiSeen = nmiOut;
        irqSeen = irqOut;
        @(posedge ref_clk);
    endtask

    task automatic event_pulse(input int idx);
        watchEvent <= 12'h001 << idx;
        @(posedge ref_clk);
        watchEvent <= '0;
        sample_outs();
    endtask

    // ================================================================
    // scenarios
    task automatic test_reset();
        reg_read(`DIRECT_OFFSET, 32'h0, `RESP_OKAY, "direct after reset");
        reg_read(`SET_OFFSET, 32'h0, `RESP_OKAY, "set after reset");
        reg_read(`STATUS_OFFSET, 32'h0, `RESP_OKAY, "status after reset");
        reg_read(`MASK_OFFSET, 32'h0, `RESP_OKAY, "mask after reset");
    endtask

    task automatic test_set_bits();
        logic [31:0] acc;
        reg_write(`SET_OFFSET, 32'h1 << `WATCH2_WRITE_BIT, `RESP_OKAY);
        reg_read(`SET_OFFSET, 32'h0000_0010, `RESP_OKAY, "region2 write only");
        reg_write(`SET_OFFSET, 32'h1 << `WATCH1_READ_BIT, `RESP_OKAY);
        reg_read(`DIRECT_OFFSET, 32'h0000_0018, `RESP_OKAY, "region1 read added");
        reg_write(`SET_OFFSET, 32'h0, `RESP_OKAY);
        reg_read(`SET_OFFSET, 32'h0000_0018, `RESP_OKAY, "zero write no effect");
        reg_write(`DIRECT_OFFSET, 32'h0, `RESP_OKAY);
        acc = 32'h0;
        for (int i = 0; i < `EVENT_COUNT; i++) begin
            acc = acc | (32'h1 << i);
            reg_write(`SET_OFFSET, 32'h1 << i, `RESP_OKAY);
            reg_read(`SET_OFFSET, acc, `RESP_OKAY, "set accumulates");
        end
    endtask

    task automatic test_direct();
        reg_write(`DIRECT_OFFSET, 32'h1 << `PERIPH1_READ_BIT, `RESP_OKAY);
        reg_read(`DIRECT_OFFSET, 32'h0000_0800, `RESP_OKAY, "periph1 read on");
        reg_read(`SET_OFFSET, 32'h0000_0800, `RESP_OKAY, "set mirrors direct");
        s_axi_wstrb <= 4'h1;
        reg_write(`DIRECT_OFFSET, 32'h0000_0FFF, `RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        reg_read(`DIRECT_OFFSET, 32'h0000_08FF, `RESP_OKAY, "lane 0 only");
        reg_write(`DIRECT_OFFSET, 32'h0, `RESP_OKAY);
        reg_read(`DIRECT_OFFSET, 32'h0, `RESP_OKAY, "periph1 read off");
        reg_write(12'h500, 32'hFFFF_FFFF, `RESP_SLVERR);
        reg_read(12'h500, 32'h0, `RESP_SLVERR, "unmapped read");
        reg_read(`DIRECT_OFFSET, 32'h0, `RESP_OKAY, "unmapped write no effect");
    endtask

    task automatic test_irq();
        reg_write(`SET_OFFSET, 32'h1 << `PERIPH1_READ_BIT, `RESP_OKAY);
        event_pulse(`PERIPH1_WRITE_BIT);
        check("nmi for disabled event", {31'h0, nmiSeen}, 32'h0);
        check("irq while masked", {31'h0, irqSeen}, 32'h0);
        reg_read(`STATUS_OFFSET, 32'h0000_0400, `RESP_OKAY, "status sticky");
        reg_write(`MASK_OFFSET, 32'h0000_0400, `RESP_OKAY);
        sample_outs();
        check("irq when unmasked", {31'h0, irqSeen}, 32'h1);
        reg_write(`STATUS_OFFSET, 32'h0000_0400, `RESP_OKAY);
        sample_outs();
        check("irq after clear", {31'h0, irqSeen}, 32'h0);
        event_pulse(`PERIPH1_READ_BIT);
        check("nmi for enabled event", {31'h0, nmiSeen}, 32'h1);
        reg_write(`STATUS_OFFSET, 32'h0000_0800, `RESP_OKAY);
        sample_outs();
        check("nmi after clear", {31'h0, nmiSeen}, 32'h0);
    endtask

    // an event while frozen must leave no trace
    task automatic test_freeze();
        clkEn <= 1'b0;
        event_pulse(`WATCH0_WRITE_BIT);
        clkEn <= 1'b1;
        @(posedge ref_clk);
        reg_read(`STATUS_OFFSET, 32'h0, `RESP_OKAY, "frozen event dropped");
    endtask

    // ================================================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        test_reset();
        test_set_bits();
        test_direct();
        test_irq();
        test_freeze();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        nFail++;
        close_out();
    end
endmodule
